/* hdl/indwd_pkg.sv */
// Constants, types and decode functions shared by the independent watchdog
package indwd_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int CNT_W  = 14;
  localparam int CTRL_W = 9;
  localparam int ST_W   = 2;
  localparam int PS_W   = 8;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADR_CTRL    = 8'h00;
  localparam logic [7:0] ADR_REFRESH = 8'h04;
  localparam logic [7:0] ADR_COUNT   = 8'h08;
  localparam logic [7:0] ADR_WINDOW  = 8'h0c;
  localparam logic [7:0] ADR_STATUS  = 8'h10;
  localparam logic [7:0] ADR_CLEAR   = 8'h14;
  localparam logic [7:0] ADR_ENABLE  = 8'h18;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_TO_LSB  = 0;
  localparam int CTRL_PS_LSB  = 2;
  localparam int CTRL_RST_BIT = 5;
  localparam int CTRL_SLP_BIT = 6;
  localparam int CTRL_SSB_BIT = 7;
  localparam int CTRL_DSL_BIT = 8;
  localparam int WIN_HI_LSB   = 0;
  localparam int WIN_LO_LSB   = 16;
  localparam int CNT_RUN_BIT  = 16;
  localparam int ST_UNF_BIT   = 0;
  localparam int ST_REF_BIT   = 1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [CTRL_W-1:0] CTRL_RST   = 9'h000;
  localparam logic [CNT_W-1:0]  WIN_HI_RST = 14'h3fff;
  localparam logic [CNT_W-1:0]  WIN_LO_RST = 14'h0000;
  localparam logic [CNT_W-1:0]  CNT_RST    = 14'h0000;
  localparam logic [ST_W-1:0]   ST_RST     = 2'h0;
  localparam logic [PS_W-1:0]   PS_ONE     = 8'h01;

  // ----------------------------------------------------------------
  // Timeout lengths in prescaled cycles
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0] TO_CYC_128  = 14'h0080;
  localparam logic [CNT_W-1:0] TO_CYC_512  = 14'h0200;
  localparam logic [CNT_W-1:0] TO_CYC_1024 = 14'h0400;
  localparam logic [CNT_W-1:0] TO_CYC_2048 = 14'h0800;
  localparam logic [CNT_W-1:0] CNT_ONE     = 14'h0001;

  typedef enum logic [1:0] {
    TO_128  = 2'b00,
    TO_512  = 2'b01,
    TO_1024 = 2'b10,
    TO_2048 = 2'b11
  } indwd_to_t;

  typedef enum logic [2:0] {
    PS_1   = 3'b000,
    PS_16  = 3'b001,
    PS_32  = 3'b010,
    PS_64  = 3'b011,
    PS_128 = 3'b100,
    PS_256 = 3'b101
  } indwd_ps_t;

  typedef enum logic {
    WD_IDLE = 1'b0,
    WD_RUN  = 1'b1
  } indwd_state_t;

  // ----------------------------------------------------------------
  // Decode functions
  // ----------------------------------------------------------------
  // Start value of the down-counter: timeout length minus one
  function automatic logic [CNT_W-1:0] indwd_reload(input logic [1:0] sel);
    logic [CNT_W-1:0] cyc;
    cyc = TO_CYC_128;
    case (indwd_to_t'(sel))
      TO_128:  cyc = TO_CYC_128;
      TO_512:  cyc = TO_CYC_512;
      TO_1024: cyc = TO_CYC_1024;
      TO_2048: cyc = TO_CYC_2048;
      default: cyc = TO_CYC_128;
    endcase
    return cyc - CNT_ONE;
  endfunction

  // Divider mask: a tick passes when all masked counter bits are ones
  function automatic logic [PS_W-1:0] indwd_ps_mask(input logic [2:0] sel);
    logic [PS_W-1:0] m;
    m = 8'h00;
    case (indwd_ps_t'(sel))
      PS_1:    m = 8'h00;
      PS_16:   m = 8'h0f;
      PS_32:   m = 8'h1f;
      PS_64:   m = 8'h3f;
      PS_128:  m = 8'h7f;
      PS_256:  m = 8'hff;
      default: m = 8'h00;
    endcase
    return m;
  endfunction

endpackage

/* hdl/indwd_prescaler.sv */
// Dedicated clock synchroniser and count prescaler of the watchdog
`timescale 1ns/10ps
module indwd_prescaler
  import indwd_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       wd_clk_i,
  input  wire logic [2:0] ps_sel,
  input  wire logic       run,
  output logic            tick_o
);

  logic            s1_q;
  logic            s2_q;
  logic            s3_q;
  logic            lvl_q;
  logic            raw_tick;
  logic [PS_W-1:0] pc_q;
  logic [PS_W-1:0] mask;

  // ----------------------------------------------------------------
  // Synchroniser
  // ----------------------------------------------------------------
  // Three stages; only the second stage reads the first
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= wd_clk_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Agreed level follows once the second and third stages match
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      lvl_q <= 1'b0;
    end else if (s2_q == s3_q) begin
      lvl_q <= s3_q;
    end
  end

  assign raw_tick = s2_q & s3_q & ~lvl_q;
  assign mask     = indwd_ps_mask(ps_sel);

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  // Divider restarts while the watchdog is idle
  always_ff @(posedge clk) begin
    if (!rst_b || !run) begin
      pc_q <= '0;
    end else if (raw_tick) begin
      pc_q <= pc_q + PS_ONE;
    end
  end

  // Count tick every 1, 16, 32, 64, 128 or 256 dedicated clock edges
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tick_o <= 1'b0;
    end else begin
      tick_o <= run & raw_tick & ((pc_q & mask) == mask);
    end
  end

  a_tick_needs_edge : assert property (@(posedge clk) disable iff (!rst_b)
    tick_o |-> $past(raw_tick) && $past(run))
    else $error("count tick without dedicated clock edge");

endmodule

/* hdl/indwd_top.sv */
// Independent watchdog: Wishbone registers, down-counter and event outputs
//
// The implementer's own choices: register access over Wishbone and the register offsets.
`timescale 1ns/10ps
module indwd_top
  import indwd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        watchdog_dedicated_clock,
  input  wire logic        auto_start,
  input  wire logic        sleep_mode,
  input  wire logic        sw_standby_mode,
  input  wire logic        deep_sleep_mode,
  output logic             nmi_req,
  output logic             reset_req,
  output logic             irq
);

  indwd_state_t     state_q;
  logic [CTRL_W-1:0] ctrl_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] win_hi_q;
  logic [CNT_W-1:0] win_lo_q;
  logic [ST_W-1:0]  status_q;
  logic [ST_W-1:0]  enable_q;
  logic             boot_q;
  logic             tick;
  logic             acc;
  logic             wr;
  logic             wr_ctrl;
  logic             wr_refresh;
  logic             running;
  logic             in_window;
  logic             refresh_ok;
  logic             refresh_bad;
  logic             underflow;
  logic             hold;
  logic             event_hit;
  logic [ST_W-1:0]  st_set;
  logic [ST_W-1:0]  st_clr;
  logic [CNT_W-1:0] reload;

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  // New request is taken when no acknowledge is pending
  assign acc        = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr         = acc & wb_we_i & wb_sel_i[0];
  assign wr_ctrl    = wr & (wb_adr_i == ADR_CTRL) & ~running;
  assign wr_refresh = wr & (wb_adr_i == ADR_REFRESH);

  // Acknowledge one cycle after the request, for one cycle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= acc;
    end
  end

  // Read data mux, unmapped and write-only offsets read zero
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (acc && !wb_we_i) begin
      wb_dat_o <= 32'h0000_0000;
      case (wb_adr_i)
        ADR_CTRL:   wb_dat_o[CTRL_W-1:0] <= ctrl_q;
        ADR_COUNT: begin
          wb_dat_o[CNT_W-1:0]  <= cnt_q;
          wb_dat_o[CNT_RUN_BIT] <= running;
        end
        ADR_WINDOW: begin
          wb_dat_o[WIN_HI_LSB +: CNT_W] <= win_hi_q;
          wb_dat_o[WIN_LO_LSB +: CNT_W] <= win_lo_q;
        end
        ADR_STATUS: wb_dat_o[ST_W-1:0] <= status_q;
        ADR_ENABLE: wb_dat_o[ST_W-1:0] <= enable_q;
        default:    wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // Control is locked once counting has started
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrl_q <= CTRL_RST;
    end else if (wr_ctrl) begin
      if (wb_sel_i[1]) begin
        ctrl_q <= wb_dat_i[CTRL_W-1:0];
      end else begin
        ctrl_q[7:0] <= wb_dat_i[7:0];
      end
    end
  end

  // Refresh window limits
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      win_hi_q <= WIN_HI_RST;
      win_lo_q <= WIN_LO_RST;
    end else if (wr && (wb_adr_i == ADR_WINDOW) && !running) begin
      win_hi_q <= wb_dat_i[WIN_HI_LSB +: CNT_W];
      win_lo_q <= wb_dat_i[WIN_LO_LSB +: CNT_W];
    end
  end

  // Interrupt enable
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      enable_q <= ST_RST;
    end else if (wr && (wb_adr_i == ADR_ENABLE)) begin
      enable_q <= wb_dat_i[ST_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Count clock
  // ----------------------------------------------------------------
  indwd_prescaler u_prescaler (
    .clk      (clk),
    .rst_b    (rst_b),
    .wd_clk_i (watchdog_dedicated_clock),
    .ps_sel   (ctrl_q[CTRL_PS_LSB +: 3]),
    .run      (running),
    .tick_o   (tick)
  );

  // ----------------------------------------------------------------
  // Start control
  // ----------------------------------------------------------------
  assign running = (state_q == WD_RUN);

  // Marks the first cycle after reset release, when the strap is read
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      boot_q <= 1'b1;
    end else begin
      boot_q <= 1'b0;
    end
  end

  // Idle until started by a refresh write or the auto-start strap
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_q <= WD_IDLE;
    end else begin
      case (state_q)
        WD_IDLE: begin
          if (wr_refresh || (boot_q && auto_start)) begin
            state_q <= WD_RUN;
          end
        end
        WD_RUN:  state_q <= WD_RUN;
        default: state_q <= WD_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Down-counter
  // ----------------------------------------------------------------
  assign reload      = indwd_reload(ctrl_q[CTRL_TO_LSB +: 2]);
  assign hold        = (sleep_mode & ctrl_q[CTRL_SLP_BIT]) |
                       (sw_standby_mode & ctrl_q[CTRL_SSB_BIT]) |
                       (deep_sleep_mode & ctrl_q[CTRL_DSL_BIT]);
  assign in_window   = (cnt_q <= win_hi_q) && (cnt_q >= win_lo_q);
  assign refresh_ok  = wr_refresh & running & in_window;
  assign refresh_bad = wr_refresh & running & ~in_window;
  assign underflow   = running & tick & ~hold & (cnt_q == CNT_RST) & ~wr_refresh;
  assign event_hit   = underflow | refresh_bad;

  // Counter loads on start and refresh, reloads after underflow
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cnt_q <= CNT_RST;
    end else if (!running) begin
      cnt_q <= reload;
    end else if (wr_refresh || underflow) begin
      cnt_q <= reload;
    end else if (tick && !hold) begin
      cnt_q <= cnt_q - CNT_ONE;
    end
  end

  // ----------------------------------------------------------------
  // Event outputs and interrupt
  // ----------------------------------------------------------------
  // One-cycle pulse on the output chosen by the mode bit
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      nmi_req   <= 1'b0;
      reset_req <= 1'b0;
    end else begin
      nmi_req   <= event_hit & ~ctrl_q[CTRL_RST_BIT];
      reset_req <= event_hit & ctrl_q[CTRL_RST_BIT];
    end
  end

  assign st_set = {refresh_bad, underflow};
  assign st_clr = (wr && (wb_adr_i == ADR_CLEAR)) ? wb_dat_i[ST_W-1:0] : ST_RST;

  // Sticky causes; a new event wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      status_q <= ST_RST;
    end else begin
      status_q <= (status_q & ~st_clr) | st_set;
    end
  end

  // Level interrupt while an enabled cause is pending
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_q & enable_q);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_ack_single_cycle : assert property (@(posedge clk) disable iff (!rst_b)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single cycle after request");

  a_count_decrement : assert property (@(posedge clk) disable iff (!rst_b)
    running && tick && !hold && !wr_refresh && cnt_q != CNT_RST
    |=> cnt_q == $past(cnt_q) - CNT_ONE)
    else $error("counter did not decrement by one on tick");

  a_refresh_reload : assert property (@(posedge clk) disable iff (!rst_b)
    refresh_ok |=> cnt_q == $past(reload) && cnt_q <= TO_CYC_2048)
    else $error("refresh did not restart from timeout length");

  a_output_exclusive : assert property (@(posedge clk) disable iff (!rst_b)
    (nmi_req |-> !ctrl_q[CTRL_RST_BIT]) && !(nmi_req && reset_req))
    else $error("unselected event output asserted");

  a_underflow_event : assert property (@(posedge clk) disable iff (!rst_b)
    underflow |=> status_q[ST_UNF_BIT] && (nmi_req || reset_req))
    else $error("underflow did not raise the event");

  a_window_error : assert property (@(posedge clk) disable iff (!rst_b)
    refresh_bad |=> status_q[ST_REF_BIT] && (nmi_req || reset_req))
    else $error("refresh outside window did not raise the event");

  a_event_cause : assert property (@(posedge clk) disable iff (!rst_b)
    nmi_req || reset_req |-> $past(underflow) || $past(refresh_bad))
    else $error("event output without underflow or refresh error");

  a_status_sticky : assert property (@(posedge clk) disable iff (!rst_b)
    status_q[ST_UNF_BIT] && !st_clr[ST_UNF_BIT] |=> status_q[ST_UNF_BIT])
    else $error("underflow status lost without a clear");

  a_lowpower_hold : assert property (@(posedge clk) disable iff (!rst_b)
    running && hold && !wr_refresh |=> $stable(cnt_q))
    else $error("counter moved while halted in low power");

  // Strap is judged only once reset is seen released at the sampling edge
  a_auto_start : assert property (@(posedge clk) disable iff (!rst_b)
    rst_b && boot_q && auto_start |=> running)
    else $error("auto start did not begin counting");

  a_refresh_start : assert property (@(posedge clk) disable iff (!rst_b)
    !running && wr_refresh |=> running)
    else $error("refresh write did not start counting");

  a_config_locked : assert property (@(posedge clk) disable iff (!rst_b)
    running |=> $stable(ctrl_q) && $stable(win_hi_q) && $stable(win_lo_q))
    else $error("configuration changed while counting");

  a_idle_silent : assert property (@(posedge clk) disable iff (!rst_b)
    !running |=> !nmi_req && !reset_req && $stable(status_q[ST_UNF_BIT]) ||
    $past(wr_refresh))
    else $error("idle watchdog raised an event");

  a_idle_no_tick : assert property (@(posedge clk) disable iff (!rst_b)
    !running |-> !tick)
    else $error("count tick while the watchdog is idle");

  a_irq_level : assert property (@(posedge clk) disable iff (!rst_b)
    ##1 irq == |($past(status_q) & $past(enable_q)))
    else $error("interrupt does not follow enabled status");

endmodule

/* tb/indwd_top_test.sv */
// Self-checking testbench of the independent watchdog
`timescale 1ns/10ps
module indwd_top_test
  import indwd_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        clk = 1'b0;
  logic        rst_b;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        wd_clk = 1'b0;
  logic        auto_start;
  logic        sleep_mode;
  logic        sw_standby_mode;
  logic        deep_sleep_mode;
  logic        nmi_req;
  logic        reset_req;
  logic        irq;
  logic [31:0] rd;
  int          bad_count;
  int          checked;
  int          wd_div = 0;
  int          nmi_n;
  int          rst_n;

  indwd_top u_indwd_top (
    .clk                      (clk),
    .rst_b                    (rst_b),
    .wb_cyc_i                 (wb_cyc_i),
    .wb_stb_i                 (wb_stb_i),
    .wb_we_i                  (wb_we_i),
    .wb_adr_i                 (wb_adr_i),
    .wb_sel_i                 (wb_sel_i),
    .wb_dat_i                 (wb_dat_i),
    .wb_dat_o                 (wb_dat_o),
    .wb_ack_o                 (wb_ack_o),
    .watchdog_dedicated_clock (wd_clk),
    .auto_start               (auto_start),
    .sleep_mode               (sleep_mode),
    .sw_standby_mode          (sw_standby_mode),
    .deep_sleep_mode          (deep_sleep_mode),
    .nmi_req                  (nmi_req),
    .reset_req                (reset_req),
    .irq                      (irq)
  );

  // ----------------------------------------------------------------
  // Clocks and event monitor
  // ----------------------------------------------------------------
  // System clock, 8 ns period
  always #4 clk = ~clk;

  // Free-running dedicated clock, five system cycles high and low
  always @(posedge clk) begin
    wd_div <= (wd_div == 4) ? 0 : wd_div + 1;
    if (wd_div == 4) begin
      wd_clk <= ~wd_clk;
    end
  end

  // Count event pulses on both outputs
  always @(posedge clk) begin
    if (rst_b !== 1'b1) begin
      nmi_n <= 0;
      rst_n <= 0;
    end else begin
      if (nmi_req === 1'b1) nmi_n <= nmi_n + 1;
      if (reset_req === 1'b1) rst_n <= rst_n + 1;
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish;
    $display("Comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk_eq(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic chk_in(input string nm, input logic [31:0] lo, input logic [31:0] hi,
                        input logic [31:0] g);
    checked++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      bad_count++;
      $display("Error %s expected %0d to %0d seen %0d", nm, lo, hi, g);
    end
  endtask

  // One classic Wishbone cycle; holds the request until ack is sampled
  task automatic wb_cycle(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    // No cycle count is assumed; a missing ack is ended by the run watchdog
    do begin
      @(posedge clk);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  task automatic do_reset(input logic a);
    @(posedge clk);
    auto_start <= a;
    rst_b      <= 1'b0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
  endtask

  // Cycles from now until either event output pulses
  task automatic wait_evt(output int c);
    c = 0;
    while (nmi_req !== 1'b1 && reset_req !== 1'b1 && c < 30000) begin
      @(posedge clk);
      c++;
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Reset values, unmapped read, idle reload per timeout, no activity unstarted
  task automatic t_idle;
    logic [31:0] len [4];
    len = '{32'h80, 32'h200, 32'h400, 32'h800};
    do_reset(1'b0);
    wb_cycle(1'b0, ADR_CTRL, 32'h0);   chk_eq("ctrl", 32'h0, rd);
    wb_cycle(1'b0, ADR_WINDOW, 32'h0); chk_eq("window", 32'h3fff, rd);
    wb_cycle(1'b0, ADR_STATUS, 32'h0); chk_eq("status", 32'h0, rd);
    wb_cycle(1'b0, ADR_ENABLE, 32'h0); chk_eq("enable", 32'h0, rd);
    wb_cycle(1'b0, 8'h1c, 32'h0);      chk_eq("unmapped", 32'h0, rd);
    for (int i = 0; i < 4; i++) begin
      wb_cycle(1'b1, ADR_CTRL, i);
      wb_cycle(1'b0, ADR_COUNT, 32'h0);
      chk_eq("idle_count", len[i] - 1, rd);
    end
    wb_cycle(1'b1, ADR_ENABLE, 32'h3);
    repeat (3000) @(posedge clk);
    chk_eq("idle_events", 32'h0, nmi_n + rst_n);
    chk_eq("idle_irq", 32'h0, {31'h0, irq});
  endtask

  // Underflow timing, output selection, status, masking and clear
  task automatic t_underflow(input logic mode, input logic [1:0] sel, input int len);
    int c;
    do_reset(1'b0);
    wb_cycle(1'b1, ADR_CTRL, {26'h0, mode, 3'h0, sel});
    wb_cycle(1'b1, ADR_REFRESH, 32'h1);
    wait_evt(c);
    chk_in("underflow_cycles", len * 10 - 15, len * 10 + 15, c);
    repeat (3) @(posedge clk);
    chk_eq("nmi_count", {31'h0, ~mode}, nmi_n);
    chk_eq("reset_count", {31'h0, mode}, rst_n);
    wb_cycle(1'b0, ADR_STATUS, 32'h0); chk_eq("status_unf", 32'h1, rd);
    chk_eq("irq_masked", 32'h0, {31'h0, irq});
    wb_cycle(1'b1, ADR_ENABLE, 32'h1);
    repeat (3) @(posedge clk);
    chk_eq("irq_enabled", 32'h1, {31'h0, irq});
    wb_cycle(1'b1, ADR_CLEAR, 32'h1);
    repeat (3) @(posedge clk);
    chk_eq("irq_cleared", 32'h0, {31'h0, irq});
    wb_cycle(1'b1, ADR_CTRL, 32'h1c);
    wb_cycle(1'b0, ADR_CTRL, 32'h0);
    chk_eq("ctrl_locked", {26'h0, mode, 3'h0, sel}, rd);
  endtask

  // Tick rate for each prescale setting
  task automatic t_prescale;
    int          dv [6];
    logic [31:0] a;
    dv = '{1, 16, 32, 64, 128, 256};
    for (int i = 0; i < 6; i++) begin
      do_reset(1'b0);
      wb_cycle(1'b1, ADR_CTRL, {27'h0, i[2:0], 2'h3});
      wb_cycle(1'b1, ADR_REFRESH, 32'h1);
      wb_cycle(1'b0, ADR_COUNT, 32'h0);
      a = rd;
      repeat (80 * dv[i]) @(posedge clk);
      wb_cycle(1'b0, ADR_COUNT, 32'h0);
      chk_in("ticks", 7, 9, {18'h0, a[13:0] - rd[13:0]});
    end
  endtask

  // Refresh outside and inside the permitted window
  task automatic t_window;
    int n;
    do_reset(1'b0);
    wb_cycle(1'b1, ADR_WINDOW, 32'h0010_0040);
    wb_cycle(1'b1, ADR_REFRESH, 32'h1);
    wb_cycle(1'b1, ADR_REFRESH, 32'h1);
    repeat (3) @(posedge clk);
    chk_eq("early_refresh", 32'h1, nmi_n);
    wb_cycle(1'b0, ADR_STATUS, 32'h0); chk_eq("status_ref", 32'h2, rd);
    n = 0;
    do begin
      wb_cycle(1'b0, ADR_COUNT, 32'h0);
      n++;
    end while (rd[13:0] > 14'h0030 && n < 300);
    wb_cycle(1'b1, ADR_REFRESH, 32'h1);
    repeat (3) @(posedge clk);
    chk_eq("good_refresh", 32'h1, nmi_n);
    wb_cycle(1'b0, ADR_COUNT, 32'h0);
    chk_in("reloaded", 32'h70, 32'h7f, {18'h0, rd[13:0]});
  endtask

  // Halt or keep counting in a low-power state
  task automatic t_lowpower(input int idx, input logic halt);
    logic [31:0] a;
    do_reset(1'b0);
    wb_cycle(1'b1, ADR_CTRL, (32'(halt) << (6 + idx)) | 32'h3);
    wb_cycle(1'b1, ADR_REFRESH, 32'h1);
    @(posedge clk);
    sleep_mode      <= (idx == 0);
    sw_standby_mode <= (idx == 1);
    deep_sleep_mode <= (idx == 2);
    repeat (20) @(posedge clk);
    wb_cycle(1'b0, ADR_COUNT, 32'h0);
    a = rd;
    repeat (300) @(posedge clk);
    wb_cycle(1'b0, ADR_COUNT, 32'h0);
    if (halt) chk_eq("halted", a, rd);
    else chk_in("kept", 29, 32, {18'h0, a[13:0] - rd[13:0]});
    sleep_mode      <= 1'b0;
    sw_standby_mode <= 1'b0;
    deep_sleep_mode <= 1'b0;
  endtask

  // Counting begins after reset with no register action
  task automatic t_autostart;
    do_reset(1'b1);
    repeat (5) @(posedge clk);
    wb_cycle(1'b0, ADR_COUNT, 32'h0);
    chk_eq("auto_run", 32'h1, {31'h0, rd[CNT_RUN_BIT]});
    auto_start <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    rst_b = 1'b0; wb_cyc_i = 1'b0; wb_stb_i = 1'b0; wb_we_i = 1'b0;
    wb_adr_i = 8'h00; wb_sel_i = 4'h0; wb_dat_i = 32'h0;
    auto_start = 1'b0; sleep_mode = 1'b0; sw_standby_mode = 1'b0; deep_sleep_mode = 1'b0;
    bad_count = 0; checked = 0;
    t_idle;
    t_underflow(1'b0, 2'h0, 128);
    t_underflow(1'b1, 2'h1, 512);
    t_prescale;
    t_window;
    t_lowpower(0, 1'b1);
    t_lowpower(1, 1'b1);
    t_lowpower(2, 1'b1);
    t_lowpower(2, 1'b0);
    t_autostart;
    tally_and_finish;
  end

  // Cuts a hang short well past the expected run length
  initial begin
    #(8 * 90000);
    bad_count++;
    tally_and_finish;
  end
endmodule
